// ==== dv/dbs_motor.sv ====
// dbs_motor: motor speed model standing behind the stop controller.
// assumes run and command come from the bench, hold from the design.
`timescale 1ns/100ps
module dbs_motor (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic run_cmd_i,
	input wire logic [15:0] freq_cmd_i,
	input wire logic hold_i,
	output logic [15:0] freq_o
);
	// ********
	// speed ramps 50 a cycle toward its target; hold drops it to zero at once
	// ********
	logic [15:0] tgt, freq_d, freq_q;
	assign freq_o = freq_q;
	always_comb
	begin
		tgt = run_cmd_i ? freq_cmd_i : 16'h0000;
		if (hold_i)
			freq_d = 16'h0000;
		else if (freq_q + 16'h0032 < tgt)
			freq_d = freq_q + 16'h0032;
		else if (freq_q > tgt + 16'h0032)
			freq_d = freq_q - 16'h0032;
		else
			freq_d = tgt;
	end
	always_ff @(posedge clock_i or negedge rst_n_i)
		if (!rst_n_i)
			freq_q <= 16'h0000;
		else
			freq_q <= freq_d;
endmodule : dbs_motor

// ==== dv/dbs_top_test.sv ====
// dbs_top_test: self-checking bench for the stop controller.
// assumes dbs_pkg, dbs_top and dbs_motor are compiled first.
`timescale 1ns/100ps
module dbs_top_test;
	import dbs_pkg::*;
	localparam int TCK = 4;
	logic clock_i, rst_n_i, run_cmd_i, mode_i, stop_i, light_i;
	logic [15:0] freq_cmd_i, out_freq_i;
	logic [6:0] terminal_i, force_i, force_o, f;
	logic [1:0] sel_i;
	logic [5:0] dly_i;
	logic shut_o, hold_o, req_o;
	logic [31:0] seed;
	int miscompares, comparisons, run_len, last_len;
	int sel_q[$];
	logic [15:0] exp_q[$];
	string nm[6] = '{"shutdown", "hold", "request", "force", "length", "below"};

	dbs_top #(.TICK_CYC(TCK), .N_TERM(7)) DUT (
		.clock_i(clock_i), .rst_n_i(rst_n_i), .run_cmd_i(run_cmd_i),
		.freq_cmd_i(freq_cmd_i), .out_freq_i(out_freq_i),
		.terminal_i(terminal_i),
		.terminal_func_i({8'h01, 8'h01, 8'h01, FUNC_COAST_STOP, 8'h01,
			8'h01, FUNC_EXT_BRAKE}),
		.internal_brake_select_i(sel_i),
		.brake_freq_threshold_i(13'h03E8), .brake_delay_time_i(dly_i),
		.brake_force_level_i(force_i), .brake_active_time_i(10'h002),
		.brake_edge_level_select_i(mode_i), .stop_method_select_i(stop_i),
		.light_duty_rating_i(light_i), .output_shutdown_o(shut_o),
		.freq_hold_zero_o(hold_o), .brake_req_o(req_o),
		.brake_force_o(force_o));
	dbs_motor MOT (.clock_i(clock_i), .rst_n_i(rst_n_i),
		.run_cmd_i(run_cmd_i), .freq_cmd_i(freq_cmd_i), .hold_i(hold_o),
		.freq_o(out_freq_i));

	// ********
	// helpers
	// ********
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction : xs
	function automatic logic [15:0] obs(input int s);
		case (s)
			0: return {15'h0000, shut_o};
			1: return {15'h0000, hold_o};
			2: return {15'h0000, req_o};
			3: return {9'h000, force_o};
			4: return last_len[15:0];
			default: return {15'h0000, out_freq_i <= 16'h03E8};
		endcase
	endfunction : obs
	task automatic check(input int s, input logic [15:0] seen,
		input logic [15:0] e);
		comparisons++;
		if (seen !== e)
		begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", nm[s], e, seen);
		end
	endtask : check
	task automatic ex(input int s, input int v);
		sel_q.push_back(s);
		exp_q.push_back(v[15:0]);
	endtask : ex
	task automatic cyc(input int n);
		repeat (n) @(posedge clock_i);
	endtask : cyc
	task automatic results();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : results
	task automatic wait_req(input logic v);
		int n;
		n = 0;
		while (req_o !== v && n < 300)
		begin
			@(posedge clock_i);
			#1;
			n++;
		end
		if (n >= 300)
		begin
			miscompares++;
			results();
		end
	endtask : wait_req
	task automatic pop_cmp();
		int s;
		s = sel_q.pop_front();
		check(s, obs(s), exp_q.pop_front());
	endtask : pop_cmp

	// ********
	// clock, monitor, watchdog
	// ********
	initial
	begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end
	always @(posedge clock_i)
		if (req_o === 1'b1)
			run_len <= run_len + 1;
		else if (run_len != 0)
		begin
			last_len <= run_len;
			run_len <= 0;
		end
	always @(negedge clock_i)
		while (sel_q.size() > 0)
			pop_cmp();
	initial
	begin
		#100000;
		miscompares++;
		results();
	end

	// ********
	// scenarios
	// ********
	initial
	begin
		{miscompares, comparisons, run_len, last_len} = '0;
		seed = xs(32'h74D4);
		{rst_n_i, run_cmd_i, mode_i, stop_i, light_i} = '0;
		{freq_cmd_i, terminal_i, sel_i} = '0;
		dly_i = 6'h01;
		f = 7'(seed % 101);
		force_i = f;
		cyc(2);
		rst_n_i <= 1'b1;
		cyc(2);
		terminal_i <= 7'h01;
		cyc(3);
		ex(0, 1);
		ex(2, 0);
		wait_req(1);
		ex(1, 1);
		ex(3, int'(f));
		wait_req(0);
		cyc(1);
		ex(4, 8);
		ex(0, 1);
		terminal_i <= 7'h00;
		cyc(3);
		ex(0, 0);
		$display("test 1 done");
		sel_i <= SEL_FREQ_CMD;
		mode_i <= MODE_LEVEL;
		run_cmd_i <= 1'b1;
		freq_cmd_i <= 16'h0BB8;
		cyc(80);
		terminal_i <= 7'h01;
		cyc(10);
		ex(2, 0);
		ex(0, 0);
		seed = xs(seed);
		terminal_i <= 7'h00;
		freq_cmd_i <= 16'(seed % 1000);
		wait_req(1);
		ex(5, 1);
		cyc(1);
		freq_cmd_i <= 16'h0BB8;
		cyc(4);
		ex(2, 0);
		$display("test 2 done");
		sel_i <= SEL_AT_STOP;
		cyc(80);
		run_cmd_i <= 1'b0;
		wait_req(1);
		ex(5, 1);
		cyc(30);
		ex(2, 1);
		run_cmd_i <= 1'b1;
		cyc(4);
		ex(2, 0);
		$display("test 3 done");
		sel_i <= SEL_DISABLE;
		run_cmd_i <= 1'b0;
		light_i <= 1'b1;
		dly_i <= 6'h00;
		seed = xs(seed);
		f = 7'(seed % 101);
		force_i <= f;
		terminal_i <= 7'h01;
		wait_req(1);
		cyc(20);
		ex(2, 1);
		ex(3, f > 70 ? 70 : int'(f));
		terminal_i <= 7'h09;
		cyc(3);
		ex(0, 1);
		ex(2, 0);
		terminal_i <= 7'h00;
		cyc(4);
		ex(0, 0);
		$display("test 4 done");
		stop_i <= STOP_COAST;
		run_cmd_i <= 1'b1;
		cyc(5);
		ex(0, 0);
		run_cmd_i <= 1'b0;
		cyc(3);
		ex(0, 1);
		cyc(2);
		$display("test 5 done");
		results();
	end
endmodule : dbs_top_test

// ==== hdl/dbs_pkg.sv ====
// dbs_pkg: constants and types for the dc braking stop controller.
// assumes a 100 MHz control clock; frequencies in 0.01 Hz steps.
package dbs_pkg;
	// ****************************************************************
	// clock and timebase
	// ****************************************************************
	localparam int CLK_PERIOD_NS = 10;
	localparam int TICK_TIME_NS = 100_000_000;
	localparam int TICK_CYCLES = TICK_TIME_NS / CLK_PERIOD_NS;
	localparam int DIV_W = 24;

	// ****************************************************************
	// input terminals
	// ****************************************************************
	localparam int NUM_TERM = 7;
	localparam int FUNC_W = 8;
	localparam logic [7:0] FUNC_EXT_BRAKE = 8'h07;
	localparam logic [7:0] FUNC_COAST_STOP = 8'h0B;

	// ****************************************************************
	// settings and limits
	// ****************************************************************
	localparam int FREQ_W = 16;
	localparam int THR_W = 13;
	localparam logic [12:0] THR_MAX = 13'h1770;
	localparam int DELAY_W = 6;
	localparam logic [5:0] DELAY_MAX = 6'h32;
	localparam int ACT_W = 10;
	localparam logic [9:0] ACT_MAX = 10'h258;
	localparam int FORCE_W = 7;
	localparam logic [6:0] FORCE_ND_MAX = 7'h64;
	localparam logic [6:0] FORCE_LD_MAX = 7'h46;
	localparam logic [6:0] FORCE_RST = 7'h00;

	localparam logic [1:0] SEL_DISABLE = 2'h0;
	localparam logic [1:0] SEL_AT_STOP = 2'h1;
	localparam logic [1:0] SEL_FREQ_CMD = 2'h2;
	localparam logic MODE_EDGE = 1'b0;
	localparam logic MODE_LEVEL = 1'b1;
	localparam logic STOP_DECEL = 1'b0;
	localparam logic STOP_COAST = 1'b1;

	typedef enum logic [1:0] {
		DBS_IDLE = 2'b00,
		DBS_DELAY = 2'b01,
		DBS_BRAKE = 2'b10,
		DBS_DONE = 2'b11
	} dbs_state_t;
endpackage : dbs_pkg

// ==== hdl/dbs_top.sv ====
// dbs_top: stop sequence with coast stop and three kinds of dc braking.
// assumes all inputs synchronous to clock_i and settings held steady.
`timescale 1ns/100ps
module dbs_top #(
	parameter int TICK_CYC = dbs_pkg::TICK_CYCLES,
	parameter int N_TERM = dbs_pkg::NUM_TERM
) (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic run_cmd_i,
	input wire logic [dbs_pkg::FREQ_W-1:0] freq_cmd_i,
	input wire logic [dbs_pkg::FREQ_W-1:0] out_freq_i,
	input wire logic [N_TERM-1:0] terminal_i,
	input wire logic [N_TERM*dbs_pkg::FUNC_W-1:0] terminal_func_i,
	input wire logic [1:0] internal_brake_select_i,
	input wire logic [dbs_pkg::THR_W-1:0] brake_freq_threshold_i,
	input wire logic [dbs_pkg::DELAY_W-1:0] brake_delay_time_i,
	input wire logic [dbs_pkg::FORCE_W-1:0] brake_force_level_i,
	input wire logic [dbs_pkg::ACT_W-1:0] brake_active_time_i,
	input wire logic brake_edge_level_select_i,
	input wire logic stop_method_select_i,
	input wire logic light_duty_rating_i,
	output logic output_shutdown_o,
	output logic freq_hold_zero_o,
	output logic brake_req_o,
	output logic [dbs_pkg::FORCE_W-1:0] brake_force_o
);
	import dbs_pkg::*;

	if (TICK_CYC < 1 || TICK_CYC >= (1 << DIV_W) || N_TERM < 1)
	begin : g_bad_param
		$error("dbs_top: tick count or terminal count out of range");
	end

	// ****************************************************************
	// terminal decode
	// ****************************************************************
	function automatic logic term_hit(input logic [N_TERM-1:0] lvl,
		input logic [N_TERM*FUNC_W-1:0] fn, input logic [7:0] code);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < N_TERM; i++)
		begin
			if (lvl[i] && fn[i*FUNC_W +: FUNC_W] == code)
				hit = 1'b1;
		end
		return hit;
	endfunction : term_hit

	logic coast_stop_input, external_brake_input, ext_en, stop_cond;
	logic fcmd_cond, trig, trig_rise, is_edge;
	logic [THR_W-1:0] thr;
	logic [DELAY_W-1:0] dly;
	logic [ACT_W-1:0] act;
	logic [FORCE_W-1:0] force_lim;
	assign coast_stop_input = term_hit(terminal_i, terminal_func_i,
		FUNC_COAST_STOP);
	assign external_brake_input = term_hit(terminal_i, terminal_func_i,
		FUNC_EXT_BRAKE);
	assign thr = (brake_freq_threshold_i > THR_MAX) ? THR_MAX :
		brake_freq_threshold_i;
	assign dly = (brake_delay_time_i > DELAY_MAX) ? DELAY_MAX :
		brake_delay_time_i;
	assign act = (brake_active_time_i > ACT_MAX) ? ACT_MAX :
		brake_active_time_i;
	assign is_edge = (brake_edge_level_select_i == MODE_EDGE);

	// ****************************************************************
	// trigger conditions
	// ****************************************************************
	logic latch_q, latch_d, trig_q;
	assign ext_en = external_brake_input &&
		(internal_brake_select_i == SEL_DISABLE ||
		internal_brake_select_i == SEL_AT_STOP);
	assign stop_cond = (internal_brake_select_i == SEL_AT_STOP) &&
		!run_cmd_i && (out_freq_i < {3'h0, thr});
	assign fcmd_cond = (internal_brake_select_i == SEL_FREQ_CMD) &&
		(freq_cmd_i <= {3'h0, thr}) &&
		(out_freq_i <= {3'h0, thr});
	assign trig = ext_en || stop_cond || latch_q || fcmd_cond;
	assign trig_rise = trig && !trig_q;

	always_comb
	begin
		latch_d = latch_q;
		if (run_cmd_i || internal_brake_select_i != SEL_AT_STOP)
			latch_d = 1'b0;
		else if (stop_cond)
			latch_d = 1'b1;
	end

	// ****************************************************************
	// timebase and sequence
	// ****************************************************************
	dbs_state_t state_q, state_d;
	logic [DIV_W-1:0] div_q, div_d;
	logic [ACT_W-1:0] cnt_q, cnt_d;
	logic tick, load;
	assign tick = (div_q == DIV_W'(TICK_CYC - 1));
	always_comb
	begin
		state_d = state_q;
		cnt_d = cnt_q;
		load = 1'b0;
		case (state_q)
			DBS_IDLE:
			begin
				if (trig_rise)
					load = 1'b1;
			end
			DBS_DELAY:
			begin
				if (trig_rise)
					load = 1'b1;
				else if (!is_edge && !trig)
					state_d = DBS_IDLE;
				else if (tick)
				begin
					cnt_d = cnt_q - 1'b1;
					if (cnt_q == 1)
					begin
						state_d = DBS_BRAKE;
						cnt_d = act;
					end
				end
			end
			DBS_BRAKE:
			begin
				if (trig_rise)
					load = 1'b1;
				else if (!is_edge)
				begin
					if (!trig)
						state_d = DBS_IDLE;
				end
				else if (cnt_q == 0)
					state_d = DBS_DONE;
				else if (tick)
				begin
					cnt_d = cnt_q - 1'b1;
					if (cnt_q == 1)
						state_d = DBS_DONE;
				end
			end
			DBS_DONE:
			begin
				if (trig_rise)
					load = 1'b1;
				else if (!trig)
					state_d = DBS_IDLE;
			end
			default:
				state_d = DBS_IDLE;
		endcase
		if (load)
		begin
			if (dly != 0)
			begin
				state_d = DBS_DELAY;
				cnt_d = {4'h0, dly};
			end
			else
			begin
				state_d = DBS_BRAKE;
				cnt_d = act;
			end
		end
	end

	always_comb
	begin
		if (load || tick || state_q == DBS_IDLE || state_q == DBS_DONE)
			div_d = '0;
		else
			div_d = div_q + 1'b1;
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	logic shut_d, hold_d, req_d;
	logic [FORCE_W-1:0] force_d;
	always_comb
	begin
		force_lim = light_duty_rating_i ? FORCE_LD_MAX : FORCE_ND_MAX;
		shut_d = coast_stop_input ||
			(stop_method_select_i == STOP_COAST && !run_cmd_i) ||
			state_q == DBS_DELAY || state_q == DBS_DONE;
		req_d = (state_q == DBS_BRAKE) && !coast_stop_input;
		hold_d = (state_q == DBS_BRAKE);
		force_d = FORCE_RST;
		if (req_d)
			force_d = (brake_force_level_i > force_lim) ? force_lim :
				brake_force_level_i;
	end

	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			state_q <= DBS_IDLE;
			cnt_q <= '0;
			div_q <= '0;
			latch_q <= 1'b0;
			trig_q <= 1'b0;
			output_shutdown_o <= 1'b0;
			freq_hold_zero_o <= 1'b0;
			brake_req_o <= 1'b0;
			brake_force_o <= FORCE_RST;
		end
		else
		begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			div_q <= div_d;
			latch_q <= latch_d;
			trig_q <= trig;
			output_shutdown_o <= shut_d;
			freq_hold_zero_o <= hold_d;
			brake_req_o <= req_d;
			brake_force_o <= force_d;
		end
	end

	// ****************************************************************
	// assertions
	// ****************************************************************
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);

	a_coast_shut: assert property (coast_stop_input |=>
		output_shutdown_o && !brake_req_o)
		else $error("coast input did not shut output off");
	a_ext_brake: assert property (state_q == DBS_IDLE && trig_rise &&
		ext_en && dly == 0 && act != 0 && !coast_stop_input ##1
		!coast_stop_input |=> brake_req_o)
		else $error("external brake did not start braking");
	a_ext_ignore: assert property (state_q == DBS_IDLE &&
		internal_brake_select_i == SEL_FREQ_CMD && !fcmd_cond |=>
		state_q == DBS_IDLE)
		else $error("external brake honoured in command mode");
	a_sel_off: assert property (internal_brake_select_i == SEL_DISABLE &&
		!external_brake_input && !latch_q |-> !trig)
		else $error("disabled selection produced a trigger");
	a_stop_start: assert property (state_q == DBS_IDLE && stop_cond &&
		!trig_q |=> state_q != DBS_IDLE)
		else $error("at-stop braking did not start");
	a_fcmd_start: assert property (state_q == DBS_IDLE && fcmd_cond &&
		!trig_q |=> state_q != DBS_IDLE)
		else $error("command braking did not start");
	a_delay_shut: assert property (state_q == DBS_DELAY |=>
		output_shutdown_o && !brake_req_o)
		else $error("output not shut off during delay");
	a_force_cap: assert property (light_duty_rating_i ##1
		light_duty_rating_i |-> brake_force_o <= FORCE_LD_MAX)
		else $error("force above light duty cap");
	a_edge_end: assert property (state_q == DBS_BRAKE && is_edge &&
		!trig_rise && tick && cnt_q == 1 |=> state_q == DBS_DONE)
		else $error("edge braking did not end on time");
	a_level_end: assert property (state_q == DBS_BRAKE && !is_edge &&
		!trig |=> state_q == DBS_IDLE ##1 !brake_req_o)
		else $error("level braking continued without trigger");
	a_latch_hold: assert property (latch_q && !run_cmd_i &&
		internal_brake_select_i == SEL_AT_STOP |=> latch_q)
		else $error("at-stop level braking released early");
	a_coast_method: assert property (stop_method_select_i == STOP_COAST &&
		!run_cmd_i |=> output_shutdown_o)
		else $error("coast stop method did not shut output off");
	a_tick_restart: assert property (load |=> div_q == 0)
		else $error("timebase not restarted on trigger");
	a_brake_out: assert property (state_q == DBS_BRAKE &&
		!coast_stop_input |=> brake_req_o && freq_hold_zero_o)
		else $error("braking outputs not driven");

	c_ext_brake: cover property (ext_en ##1 state_q == DBS_BRAKE);
	c_delay_brake: cover property (state_q == DBS_DELAY ##1
		state_q == DBS_BRAKE);
	c_edge_done: cover property (state_q == DBS_BRAKE ##1
		state_q == DBS_DONE);
	c_fcmd: cover property (fcmd_cond && state_q == DBS_BRAKE);
endmodule : dbs_top
